// file: logic/sysreg_store_and_subtract_exec.sv
`timescale 1ns/1ps
// Overview of operation
// - copy mac halves or procedure register to dest
// - push: dest minus four, then longword write
// - copy fpu comm or masked status to dest
// - fpu push: decrement, write comm or masked status
// - raise tlb miss, protection, address error on write
// - plain subtract wraps, t flag untouched
// - borrow subtract: n minus m minus t
// - t set when either borrow step borrowed
module sysreg_store_and_subtract_exec (
    input  wire logic                       clk,       // 100 mhz core clock
    input  wire logic                       nrst,      // sync reset, active low
    input  wire logic                       op_valid,  // opcode offered this cycle
    input  wire logic [15:0]                opcode,    // instruction word
    input  wire sysreg_sub_pkg::sysregs_s   sysregs,   // system register values
    input  wire logic [31:0]                gpr_n,     // dest_gpr current value
    input  wire logic [31:0]                gpr_m,     // source_gpr current value
    input  wire sysreg_sub_pkg::mem_fault_s mem_fault, // fault for the write shown on mem_wr, same cycle
    output logic                            busy,      // push awaiting fault check
    output logic                            wb_valid,  // dest_gpr write pulse
    output logic [3:0]                      wb_idx,    // dest_gpr index
    output logic [31:0]                     wb_data,   // dest_gpr write data
    output sysreg_sub_pkg::mem_wr_s         mem_wr,    // longword write request
    output logic                            t_flag,    // t flag
    output logic [31:0]                     pc,        // program counter
    output sysreg_sub_pkg::mem_fault_s      exc,       // exception pulses
    output logic                            illegal    // opcode not in this group
);
    import sysreg_sub_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // store source decode shared by both forms
    function automatic logic [31:0] sel_val(input src_sel_e s, input sysregs_s r);
        case (s)
            src_mac_high_half:  sel_val = r.mac_high_half;
            src_mac_low_half:  sel_val = r.mac_low_half;
            src_proc:  sel_val = r.procedure_return_reg;
            src_fcomm: sel_val = r.fpu_comm_reg;
            default:   sel_val = r.fpu_status_control & fstat_mask_c;
        endcase
    endfunction

    logic        is_store;   // register-form store
    logic        is_push;    // pre-decrement push
    logic        is_sub;     // plain subtract
    logic        is_borrow_subtract_op;    // borrow subtract
    src_sel_e    src;        // selected system register
    logic [31:0] diff1;      // n minus m
    logic [31:0] diff2;      // diff1 minus t
    logic [31:0] push_addr;  // decremented pointer

    always_comb begin
        is_store = 1'b0;
        is_push  = 1'b0;
        src      = src_mac_high_half;
        // low byte picks the register for both forms
        case (opcode[7:0])
            lo_mac_high_st: begin is_store = opcode[15:12] == grp_zero_c; src = src_mac_high_half;  end
            lo_mac_low_st:  begin is_store = opcode[15:12] == grp_zero_c; src = src_mac_low_half;  end
            lo_proc_st:     begin is_store = opcode[15:12] == grp_zero_c; src = src_proc;  end
            lo_fcomm_st:    begin is_store = opcode[15:12] == grp_zero_c; src = src_fcomm; end
            lo_fstat_st:    begin is_store = opcode[15:12] == grp_zero_c; src = src_fstat; end
            lo_mac_high_pu: begin is_push  = opcode[15:12] == grp_four_c; src = src_mac_high_half;  end
            lo_mac_low_pu:  begin is_push  = opcode[15:12] == grp_four_c; src = src_mac_low_half;  end
            lo_proc_pu:     begin is_push  = opcode[15:12] == grp_four_c; src = src_proc;  end
            lo_fcomm_pu:    begin is_push  = opcode[15:12] == grp_four_c; src = src_fcomm; end
            lo_fstat_pu:    begin is_push  = opcode[15:12] == grp_four_c; src = src_fstat; end
            default: begin
                is_store = 1'b0;
            end
        endcase
    end

    // no immediate subtract exists; only register forms decode
    assign is_sub    = opcode[15:12] == grp_three_c && opcode[3:0] == lo_sub_c;
    assign is_borrow_subtract_op   = opcode[15:12] == grp_three_c && opcode[3:0] == lo_borrow_subtract_op_c;
    assign diff1     = gpr_n - gpr_m;
    assign diff2     = diff1 - {31'h0, t_flag};
    assign push_addr = gpr_n - push_step_c;

    // ------------------------------------------------------------
    // execution state
    // ------------------------------------------------------------
    // a push holds busy one cycle so a fault can veto the pc step;
    // the caller must not offer an opcode while busy is high
    logic accept;      // opcode taken this cycle
    assign accept = op_valid && !busy;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else begin
            busy <= accept && is_push;
        end
    end

    // ------------------------------------------------------------
    // register write-back
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wb_valid <= 1'b0;
            wb_idx   <= 4'h0;
            wb_data  <= 32'h0;
        end else begin
            wb_valid <= accept && (is_store || is_push || is_sub || is_borrow_subtract_op);
            wb_idx   <= opcode[11:8];
            if (is_store) begin
                wb_data <= sel_val(src, sysregs);
            end else if (is_push) begin
                wb_data <= push_addr;
            end else if (is_sub) begin
                wb_data <= diff1;
            end else begin
                wb_data <= diff2;
            end
        end
    end

    // ------------------------------------------------------------
    // memory write
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mem_wr <= '0;
        end else begin
            mem_wr.valid <= accept && is_push;
            mem_wr.addr  <= push_addr;
            mem_wr.data  <= sel_val(src, sysregs);
        end
    end

    // ------------------------------------------------------------
    // t flag: only borrow subtract touches it
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            t_flag <= 1'b0;
        end else if (accept && is_borrow_subtract_op) begin
            t_flag <= (gpr_n < diff1) || (diff1 < diff2);
        end
    end

    // ------------------------------------------------------------
    // exceptions and pc
    // ------------------------------------------------------------
    logic fault_any;   // any fault on the pending push
    assign fault_any = busy && (mem_fault.tlb_miss || mem_fault.tlb_prot || mem_fault.addr_err);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            exc <= '0;
        end else begin
            exc <= busy ? mem_fault : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc <= pc_reset_c;
        end else if ((accept && (is_store || is_sub || is_borrow_subtract_op)) || (busy && !fault_any)) begin
            pc <= pc + pc_step_c;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            illegal <= 1'b0;
        end else begin
            illegal <= accept && !(is_store || is_push || is_sub || is_borrow_subtract_op);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_store_copies_mac_high_half: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && opcode[15:12] == grp_zero_c && opcode[7:0] == lo_mac_high_st
        |=> wb_valid && wb_data == $past(sysregs.mac_high_half) && $stable(t_flag))
        else $error("register store of high half wrong");
    a_push_addr_data: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_push
        |=> mem_wr.valid && mem_wr.addr == $past(gpr_n) - push_step_c && wb_data == mem_wr.addr)
        else $error("push address or write-back wrong");
    a_fstat_masked: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_store && opcode[7:0] == lo_fstat_st
        |=> wb_data == ($past(sysregs.fpu_status_control) & fstat_mask_c))
        else $error("status copy not masked");
    a_fpush_masked: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_push && opcode[7:0] == lo_fstat_pu
        |=> mem_wr.data == ($past(sysregs.fpu_status_control) & fstat_mask_c))
        else $error("status push not masked");
    a_fault_raised: assert property (@(posedge clk) disable iff (!nrst)
        busy && mem_fault.addr_err |=> exc.addr_err ##1 !exc.addr_err)
        else $error("address error not raised");
    a_sub_result: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_sub
        |=> wb_data == $past(gpr_n) - $past(gpr_m) && $stable(t_flag))
        else $error("subtract result wrong");
    a_borrow_subtract_op_result: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_borrow_subtract_op
        |=> wb_data == $past(gpr_n) - $past(gpr_m) - {31'h0, $past(t_flag)})
        else $error("borrow subtract result wrong");
    a_borrow_subtract_op_borrow: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_borrow_subtract_op
        |=> t_flag == ({1'b0, $past(gpr_n)} < {1'b0, $past(gpr_m)} + {32'h0, $past(t_flag)}))
        else $error("borrow flag wrong");
    a_pc_step: assert property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && (is_sub || is_store) |=> pc == $past(pc) + pc_step_c)
        else $error("pc not advanced");
    a_pc_hold_fault: assert property (@(posedge clk) disable iff (!nrst)
        fault_any |=> pc == $past(pc))
        else $error("pc advanced over a fault");

    c_push_clean: cover property (@(posedge clk) disable iff (!nrst)
        busy && !fault_any);
    c_push_fault: cover property (@(posedge clk) disable iff (!nrst)
        fault_any);
    c_borrow_subtract_op_borrow: cover property (@(posedge clk) disable iff (!nrst)
        op_valid && !busy && is_borrow_subtract_op ##1 t_flag);
endmodule

// file: logic/sysreg_sub_pkg.sv
package sysreg_sub_pkg;

    // ------------------------------------------------------------
    // opcode fields and patterns
    // ------------------------------------------------------------
    localparam logic [3:0]  grp_zero_c      = 4'h0;   // register-form store group
    localparam logic [3:0]  grp_four_c      = 4'h4;   // push group
    localparam logic [3:0]  grp_three_c     = 4'h3;   // arithmetic group
    localparam logic [7:0]  lo_mac_high_st  = 8'h0a;  // copy high half
    localparam logic [7:0]  lo_mac_low_st   = 8'h1a;  // copy low half
    localparam logic [7:0]  lo_proc_st      = 8'h2a;  // copy procedure register
    localparam logic [7:0]  lo_fcomm_st     = 8'h5a;  // copy fpu comm
    localparam logic [7:0]  lo_fstat_st     = 8'h6a;  // copy fpu status
    localparam logic [7:0]  lo_mac_high_pu  = 8'h02;  // push high half
    localparam logic [7:0]  lo_mac_low_pu   = 8'h12;  // push low half
    localparam logic [7:0]  lo_proc_pu      = 8'h22;  // push procedure register
    localparam logic [7:0]  lo_fcomm_pu     = 8'h52;  // push fpu comm
    localparam logic [7:0]  lo_fstat_pu     = 8'h62;  // push fpu status
    localparam logic [3:0]  lo_sub_c        = 4'h8;   // plain subtract
    localparam logic [3:0]  lo_borrow_subtract_op_c       = 4'ha;   // borrow subtract

    // ------------------------------------------------------------
    // data constants
    // ------------------------------------------------------------
    localparam logic [31:0] fstat_mask_c    = 32'h003fffff; // status read mask
    localparam logic [31:0] push_step_c     = 32'h00000004; // pre-decrement amount
    localparam logic [31:0] pc_step_c       = 32'h00000002; // opcode width in bytes
    localparam logic [31:0] pc_reset_c      = 32'h00000000; // pc after reset

    // source selection for stores
    typedef enum {src_mac_high_half, src_mac_low_half, src_proc, src_fcomm, src_fstat} src_sel_e;

    // system register values offered to the unit
    typedef struct packed {
        logic [31:0] mac_high_half;
        logic [31:0] mac_low_half;
        logic [31:0] procedure_return_reg;
        logic [31:0] fpu_comm_reg;
        logic [31:0] fpu_status_control;
    } sysregs_s;

    // memory write request
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
    } mem_wr_s;

    // memory fault report
    typedef struct packed {
        logic tlb_miss;
        logic tlb_prot;
        logic addr_err;
    } mem_fault_s;

endpackage

// file: tb/data_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// data memory seen through the load/store path
// ------------------------------------------------------------
module data_mem_model (
    input  wire sysreg_sub_pkg::mem_wr_s    mem_wr,    // longword write from the unit
    input  wire sysreg_sub_pkg::mem_fault_s fault_cmd, // fault the bench wants reported
    output sysreg_sub_pkg::mem_fault_s      mem_fault  // answer for the current write
);
    import sysreg_sub_pkg::*;

    // answer in the cycle the write is shown; misaligned longwords
    // always fail, and outside a write all fault lines are high so a
    // unit that listens at the wrong time gets caught
    always_comb begin
        if (mem_wr.valid) begin
            mem_fault          = fault_cmd;
            mem_fault.addr_err = fault_cmd.addr_err | (mem_wr.addr[1:0] != 2'h0);
        end else begin
            mem_fault = 3'h7; // stale lines, must be ignored
        end
    end
endmodule

// file: tb/test_sysreg_store_and_subtract_exec.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_sysreg_store_and_subtract_exec;
    import sysreg_sub_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk, nrst, op_valid, busy, wb_valid, t_flag, illegal, exp_t;
    logic [15:0] opcode;
    logic [31:0] gpr_n, gpr_m, wb_data, pc, exp_pc;
    logic [3:0]  wb_idx;
    sysregs_s    sysregs;
    mem_wr_s     mem_wr;
    mem_fault_s  mem_fault, exc, fault_cmd;
    int          failures, checked;
    logic [31:0] cn [3] = '{32'h5, 32'h0, 32'h0};   // borrow chain minuends
    logic [31:0] cm [3] = '{32'h2, 32'h1, 32'h0};   // borrow chain subtrahends
    logic [31:0] cr [3] = '{32'h3, 32'hffff_ffff, 32'hffff_ffff}; // borrow chain results
    logic        ct [3] = '{1'b0, 1'b1, 1'b1};      // borrow after each step
    logic [7:0]  lo_st [5] = '{lo_mac_high_st, lo_mac_low_st, lo_proc_st, lo_fcomm_st,
                               lo_fstat_st};
    logic [7:0]  lo_pu [5] = '{lo_mac_high_pu, lo_mac_low_pu, lo_proc_pu, lo_fcomm_pu,
                               lo_fstat_pu};
    logic [31:0] exp_v [5];                       // expected store values

    sysreg_store_and_subtract_exec dut (.clk(clk), .nrst(nrst), .op_valid(op_valid),
        .opcode(opcode), .sysregs(sysregs), .gpr_n(gpr_n), .gpr_m(gpr_m),
        .mem_fault(mem_fault), .busy(busy), .wb_valid(wb_valid), .wb_idx(wb_idx),
        .wb_data(wb_data), .mem_wr(mem_wr), .t_flag(t_flag), .pc(pc), .exc(exc),
        .illegal(illegal));
    data_mem_model mem (.mem_wr(mem_wr), .fault_cmd(fault_cmd), .mem_fault(mem_fault));

    // ------------------------------------------------------------
    // clock, driver and check tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task close_out;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // offer one opcode for one cycle; returns when its results have landed
    task run(input logic [15:0] op, input logic [31:0] vn, input logic [31:0] vm);
        @(negedge clk);
        op_valid = 1'b1;
        opcode   = op;
        gpr_n    = vn;
        gpr_m    = vm;
        @(negedge clk);
        op_valid = 1'b0;
    endtask

    task chk_op(input logic [31:0] d);
        `CHK("wb_valid", 1'b1, wb_valid)
        `CHK("wb_idx", opcode[11:8], wb_idx)
        `CHK("wb_data", d, wb_data)
        `CHK("t_flag", exp_t, t_flag)
        `CHK("pc", exp_pc, pc)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0; op_valid = 1'b0; opcode = 16'h0; gpr_n = 32'h0; gpr_m = 32'h0;
        fault_cmd = 3'h0; failures = 0; checked = 0; exp_pc = pc_reset_c; exp_t = 1'b0;
        sysregs = {32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888, 32'hffff_ffff};
        exp_v = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888,
                  32'hffff_ffff & fstat_mask_c};
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        `CHK("pc", pc_reset_c, pc)
        `CHK("t_flag", 1'b0, t_flag)
        // borrow chain; ends with t set so later ops prove t untouched
        for (int i = 0; i < 3; i++) begin
            exp_t = ct[i];
            run({grp_three_c, 4'h1, 4'h2, lo_borrow_subtract_op_c}, cn[i], cm[i]);
            exp_pc = exp_pc + pc_step_c;
            chk_op(cr[i]);
        end
        // register-form stores, status value masked
        for (int i = 0; i < 5; i++) begin
            run({grp_zero_c, 4'(i + 3), lo_st[i]}, 32'hdead_0000, 32'h0);
            exp_pc = exp_pc + pc_step_c;
            chk_op(exp_v[i]);
            `CHK("mem_wr.valid", 1'b0, mem_wr.valid)
        end
        // pushes: pointer drops by four, longword written there
        for (int i = 0; i < 5; i++) begin
            run({grp_four_c, 4'hf, lo_pu[i]}, 32'h1000_0004, 32'h0);
            chk_op(32'h1000_0000);
            `CHK("busy", 1'b1, busy)
            `CHK("mem_wr.valid", 1'b1, mem_wr.valid)
            `CHK("mem_wr.addr", 32'h1000_0000, mem_wr.addr)
            `CHK("mem_wr.data", exp_v[i], mem_wr.data)
            @(negedge clk);
            exp_pc = exp_pc + pc_step_c;
            `CHK("pc", exp_pc, pc)
            `CHK("exc", 3'h0, exc)
            `CHK("busy", 1'b0, busy)
        end
        // faulting pushes, last one misaligned; pc must hold
        for (int k = 0; k < 4; k++) begin
            fault_cmd = (k < 3) ? 3'(1 << k) : 3'h0;
            run({grp_four_c, 4'h9, lo_mac_high_pu}, (k < 3) ? 32'h2000_0004 : 32'h2000_0006,
                32'h0);
            @(negedge clk);
            `CHK("exc", (k < 3) ? 3'(1 << k) : 3'h1, exc)
            `CHK("pc", exp_pc, pc)
        end
        fault_cmd = 3'h0;
        // plain subtract wraps and leaves t alone
        run({grp_three_c, 4'h2, 4'h3, lo_sub_c}, 32'h8000_0000, 32'h1);
        exp_pc = exp_pc + pc_step_c;
        chk_op(32'h7fff_ffff);
        run({grp_three_c, 4'h4, 4'h5, lo_sub_c}, 32'h0, 32'h1);
        exp_pc = exp_pc + pc_step_c;
        chk_op(32'hffff_ffff);
        // add-immediate encoding is not in this group
        run(16'h72fc, 32'h0, 32'h0);
        `CHK("illegal", 1'b1, illegal)
        `CHK("pc", exp_pc, pc)
        // an opcode offered while busy is dropped
        run({grp_four_c, 4'h6, lo_proc_pu}, 32'h3000_0008, 32'h0);
        `CHK("busy", 1'b1, busy)
        op_valid = 1'b1;
        opcode = {grp_three_c, 4'h2, 4'h3, lo_sub_c};
        @(negedge clk);
        op_valid = 1'b0;
        exp_pc = exp_pc + pc_step_c;
        `CHK("wb_valid", 1'b0, wb_valid)
        `CHK("pc", exp_pc, pc)
        // mid-run reset: pc and t return to their reset values
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        `CHK("pc", pc_reset_c, pc)
        `CHK("t_flag", 1'b0, t_flag)
        close_out();
    end
endmodule
